// ==== hw/sysref_cal_pkg.sv ====
// Purpose: shared constants and types for the sysref timing calibration control
// Assumes: byte-addressed register port, 24-bit data, ref_clk is the device clock
// Notes:   every offset, field position and reset value lives here
package sysref_cal_pkg;

    // ********************************************************
    // widths
    // ********************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 24;
    localparam int TAD_W  = 17;
    localparam int CODE_W = 2;
    localparam int CNT_W  = 32;

    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [ADDR_W-1:0] ADDR_NOISE = 12'h2a2;
    localparam logic [ADDR_W-1:0] ADDR_EN    = 12'h2b0;
    localparam logic [ADDR_W-1:0] ADDR_CFG   = 12'h2b1;
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 12'h2b2;
    localparam logic [ADDR_W-1:0] ADDR_TAD   = 12'h2b5;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [7:0]       RST_NOISE = 8'h00;
    localparam logic [7:0]       RST_EN    = 8'h00;
    localparam logic [7:0]       RST_CFG   = 8'h05;
    localparam logic [TAD_W-1:0] RST_TAD   = 17'h00000;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int EN_BIT      = 0;
    localparam int AVG_LSB     = 2;
    localparam int DUR_LSB     = 0;
    localparam int DIG_NS_BIT  = 5;
    localparam int CLK_NS_BIT  = 4;
    localparam int DONE_BIT    = 17;
    localparam int STAT_PAD_W  = DATA_W - TAD_W - 1;
    localparam int BYTE_PAD_W  = DATA_W - 8;

    // ********************************************************
    // calibration time bound: unit * 4^(avg + dur + 2)
    // ********************************************************
    localparam int CAL_UNIT_CYCLES = 384 * 19;
    localparam logic [4:0] EXP_OFFSET = 5'h02;

    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} cal_state_t;

endpackage : sysref_cal_pkg

// ==== hw/cal_ctrl_if.sv ====
// Purpose: carrier between the register front and the calibration sequencer
// Assumes: single ref_clk domain
// Notes:   start is a one-cycle pulse, the rest are levels
`timescale 1ns/1ps
interface cal_ctrl_if;
    logic                                enable;
    logic                                start;
    logic [sysref_cal_pkg::CODE_W-1:0]   avgCode;
    logic [sysref_cal_pkg::CODE_W-1:0]   durCode;
    logic                                done;
    logic [sysref_cal_pkg::TAD_W-1:0]    result;

    modport ctrl (output enable, start, avgCode, durCode, input done, result);
    modport seq  (input enable, start, avgCode, durCode, output done, result);
endinterface : cal_ctrl_if

// ==== hw/cal_sequencer.sv ====
// Purpose: runs one calibration pass and holds its delay result
// Assumes: measurement datapath lives outside and reports on measDone
// Notes:   pass is forced to end at the worst-case time bound
`timescale 1ns/1ps
module cal_sequencer #(
    parameter int CalUnit = sysref_cal_pkg::CAL_UNIT_CYCLES
) (
    input  wire logic                             ref_clk,
    input  wire logic                             srst,
    cal_ctrl_if.seq                               ctl,
    input  wire logic                             measDone,
    input  wire logic [sysref_cal_pkg::TAD_W-1:0] measDelay
);
    sysref_cal_pkg::cal_state_t           state_q;
    logic [sysref_cal_pkg::CNT_W-1:0]     cnt_q;
    logic [sysref_cal_pkg::CNT_W-1:0]     bound;
    logic [4:0]                           shiftAmt;
    logic [sysref_cal_pkg::TAD_W-1:0]     result_q;

    // ********************************************************
    // time bound from the two codes
    // ********************************************************
    // each step of 4 is two bit positions
    assign shiftAmt = ({3'h0, ctl.avgCode} + {3'h0, ctl.durCode} + sysref_cal_pkg::EXP_OFFSET) << 1;
    assign bound    = sysref_cal_pkg::CNT_W'(CalUnit) << shiftAmt;

    // ********************************************************
    // pass state
    // ********************************************************
    // clearing enable aborts at once, a pending pass never outlives it
    always_ff @(posedge ref_clk)
    begin
        if (srst || !ctl.enable)
            state_q <= sysref_cal_pkg::CAL_IDLE;
        else if (ctl.start)
            state_q <= sysref_cal_pkg::CAL_RUN;
        else
        begin
            case (state_q)
                sysref_cal_pkg::CAL_RUN:
                    if (measDone || cnt_q >= bound - 1'b1)
                        state_q <= sysref_cal_pkg::CAL_DONE;
                default: state_q <= state_q;
            endcase
        end
    end

    // cycle counter of the running pass
    always_ff @(posedge ref_clk)
    begin
        if (srst || ctl.start || state_q != sysref_cal_pkg::CAL_RUN)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end

    // result captured when measDone ends a pass and held after it; a pass ended by the bound keeps the old result
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            result_q <= sysref_cal_pkg::RST_TAD;
        else if (state_q == sysref_cal_pkg::CAL_RUN && measDone && !ctl.start)
            result_q <= measDelay;
    end

    assign ctl.done   = (state_q == sysref_cal_pkg::CAL_DONE);
    assign ctl.result = result_q;

    // ********************************************************
    // checks
    // ********************************************************
    run_bound_a: assert property (@(posedge ref_clk) disable iff (srst)
        state_q == sysref_cal_pkg::CAL_RUN |-> cnt_q < bound)
        else $error("calibration pass overran its time bound");

    result_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        state_q == sysref_cal_pkg::CAL_DONE |=> $stable(result_q))
        else $error("held calibration result changed after completion");

endmodule : cal_sequencer

// ==== hw/delay_select.sv ====
// Purpose: picks the sample-clock delay source and registers it
// Assumes: both sources are on ref_clk
// Notes:   one cycle from select or source change to output
`timescale 1ns/1ps
module delay_select (
    input  wire logic                             ref_clk,
    input  wire logic                             srst,
    input  wire logic                             useCal,
    input  wire logic [sysref_cal_pkg::TAD_W-1:0] manualDelay,
    input  wire logic [sysref_cal_pkg::TAD_W-1:0] calDelay,
    output logic      [sysref_cal_pkg::TAD_W-1:0] delayOut_q
);
    // ********************************************************
    // output register
    // ********************************************************
    // manual value is ignored entirely while calibration is on
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            delayOut_q <= sysref_cal_pkg::RST_TAD;
        else if (useCal)
            delayOut_q <= calDelay;
        else
            delayOut_q <= manualDelay;
    end
endmodule : delay_select

// ==== hw/sysref_timing_calibration_ctrl.sv ====
// Purpose: register front and control of automatic sysref timing calibration
// Assumes: ref_clk is the device clock; register port on the same clock
// Notes:   read data appears one cycle after regRdEn
`timescale 1ns/1ps
module sysref_timing_calibration_ctrl #(
    parameter int CalUnit = sysref_cal_pkg::CAL_UNIT_CYCLES
) (
    input  wire logic                              ref_clk,
    input  wire logic                              srst,
    input  wire logic [sysref_cal_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [sysref_cal_pkg::DATA_W-1:0] regWrData,
    input  wire logic                              regWrEn,
    input  wire logic                              regRdEn,
    output logic      [sysref_cal_pkg::DATA_W-1:0] regRdData_q,
    input  wire logic                              measDone,
    input  wire logic [sysref_cal_pkg::TAD_W-1:0]  measDelay,
    output logic                                   calStart_q,
    output logic      [sysref_cal_pkg::CODE_W-1:0] calAveragingCode_q,
    output logic      [sysref_cal_pkg::CODE_W-1:0] accumulationDurationCode_q,
    output logic                                   calCompleteFlag_q,
    output logic      [sysref_cal_pkg::TAD_W-1:0]  sampleDelay_q,
    output logic                                   digitalSupplyNoiseSuppress_q,
    output logic                                   clockSupplyNoiseSuppress_q
);
    logic [7:0]                           noiseSuppressCtrlReg_q;
    logic [7:0]                           sysrefCalEnableReg_q;
    logic [7:0]                           sysrefCalConfigReg_q;
    logic [sysref_cal_pkg::TAD_W-1:0]     tadReg_q;
    logic                                 wrNoise;
    logic                                 wrEn;
    logic                                 wrCfg;
    logic                                 wrTad;
    logic                                 calEnableBit;
    logic                                 startNow;
    logic [sysref_cal_pkg::DATA_W-1:0]    rdMux;
    logic [sysref_cal_pkg::DATA_W-1:0]    statusWord;

    cal_ctrl_if ctl ();

    // ********************************************************
    // write decode
    // ********************************************************
    // status register is read-only here; writes to it are dropped
    assign wrNoise = regWrEn && (regAddr == sysref_cal_pkg::ADDR_NOISE);
    assign wrEn    = regWrEn && (regAddr == sysref_cal_pkg::ADDR_EN);
    assign wrCfg   = regWrEn && (regAddr == sysref_cal_pkg::ADDR_CFG);
    assign wrTad   = regWrEn && (regAddr == sysref_cal_pkg::ADDR_TAD);

    assign calEnableBit = sysrefCalEnableReg_q[sysref_cal_pkg::EN_BIT];

    // only a write that lifts the bit from zero starts a pass
    // a repeated write of one is refused; a restart needs a zero first
    assign startNow = wrEn && regWrData[sysref_cal_pkg::EN_BIT] && !calEnableBit;

    // ********************************************************
    // registers
    // ********************************************************
    // supply noise suppression control, all bits writable
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            noiseSuppressCtrlReg_q <= sysref_cal_pkg::RST_NOISE;
        else if (wrNoise)
            noiseSuppressCtrlReg_q <= regWrData[7:0];
    end

    // calibration enable, reserved bits kept as storage
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            sysrefCalEnableReg_q <= sysref_cal_pkg::RST_EN;
        else if (wrEn)
            sysrefCalEnableReg_q <= regWrData[7:0];
    end

    // calibration configuration; changing it mid-pass is not guarded
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            sysrefCalConfigReg_q <= sysref_cal_pkg::RST_CFG;
        else if (wrCfg)
            sysrefCalConfigReg_q <= regWrData[7:0];
    end

    // manual timing adjust
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            tadReg_q <= sysref_cal_pkg::RST_TAD;
        else if (wrTad)
            tadReg_q <= regWrData[sysref_cal_pkg::TAD_W-1:0];
    end

    // ********************************************************
    // sequencer link
    // ********************************************************
    assign ctl.enable  = calEnableBit;
    assign ctl.start   = calStart_q;
    assign ctl.avgCode = calAveragingCode_q;
    assign ctl.durCode = accumulationDurationCode_q;

    // start is registered so the datapath sees it with the codes
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            calStart_q <= 1'b0;
        else
            calStart_q <= startNow;
    end

    // codes exported to the measurement datapath
    // they lag the config register by one edge, so config must settle before enable
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            calAveragingCode_q         <= sysref_cal_pkg::RST_CFG[sysref_cal_pkg::AVG_LSB +: sysref_cal_pkg::CODE_W];
            accumulationDurationCode_q <= sysref_cal_pkg::RST_CFG[sysref_cal_pkg::DUR_LSB +: sysref_cal_pkg::CODE_W];
        end
        else
        begin
            calAveragingCode_q         <= sysrefCalConfigReg_q[sysref_cal_pkg::AVG_LSB +: sysref_cal_pkg::CODE_W];
            accumulationDurationCode_q <= sysrefCalConfigReg_q[sysref_cal_pkg::DUR_LSB +: sysref_cal_pkg::CODE_W];
        end
    end

    cal_sequencer #(
        .CalUnit (CalUnit)
    ) u_seq (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .ctl       (ctl.seq),
        .measDone  (measDone),
        .measDelay (measDelay)
    );

    // ********************************************************
    // flags and pins
    // ********************************************************
    // done reaches the flag one edge late, so the flag stays up for one cycle after enable is cleared
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            calCompleteFlag_q <= 1'b0;
        else
            calCompleteFlag_q <= calEnableBit && ctl.done;
    end

    // suppression enables pass through one register on their way to the analog side
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            digitalSupplyNoiseSuppress_q <= 1'b0;
            clockSupplyNoiseSuppress_q   <= 1'b0;
        end
        else
        begin
            digitalSupplyNoiseSuppress_q <= noiseSuppressCtrlReg_q[sysref_cal_pkg::DIG_NS_BIT];
            clockSupplyNoiseSuppress_q   <= noiseSuppressCtrlReg_q[sysref_cal_pkg::CLK_NS_BIT];
        end
    end

    // registered mux, so the delay pins never see a glitch on a source switch
    delay_select u_sel (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .useCal      (calEnableBit),
        .manualDelay (tadReg_q),
        .calDelay    (ctl.result),
        .delayOut_q  (sampleDelay_q)
    );

    // ********************************************************
    // read path
    // ********************************************************
    // done bit taken live, so a read right after a disabling write never shows it
    assign statusWord = {{sysref_cal_pkg::STAT_PAD_W{1'b0}}, calEnableBit && ctl.done, ctl.result};

    // unmapped addresses read as zero
    always_comb
    begin
        case (regAddr)
            sysref_cal_pkg::ADDR_NOISE: rdMux = {{sysref_cal_pkg::BYTE_PAD_W{1'b0}}, noiseSuppressCtrlReg_q};
            sysref_cal_pkg::ADDR_EN:    rdMux = {{sysref_cal_pkg::BYTE_PAD_W{1'b0}}, sysrefCalEnableReg_q};
            sysref_cal_pkg::ADDR_CFG:   rdMux = {{sysref_cal_pkg::BYTE_PAD_W{1'b0}}, sysrefCalConfigReg_q};
            sysref_cal_pkg::ADDR_STAT:  rdMux = statusWord;
            sysref_cal_pkg::ADDR_TAD:   rdMux = {{(sysref_cal_pkg::DATA_W - sysref_cal_pkg::TAD_W){1'b0}}, tadReg_q};
            default:                    rdMux = '0;
        endcase
    end

    // read data is held until the next read
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            regRdData_q <= '0;
        else if (regRdEn)
            regRdData_q <= rdMux;
    end

    // ********************************************************
    // checks
    // ********************************************************
    manual_path_a: assert property (@(posedge ref_clk) disable iff (srst)
        !calEnableBit |=> sampleDelay_q == $past(tadReg_q))
        else $error("manual delay not driven while calibration is off");

    auto_path_a: assert property (@(posedge ref_clk) disable iff (srst)
        calEnableBit && wrTad |=> sampleDelay_q == $past(ctl.result))
        else $error("manual register leaked through while calibration is on");

    start_edge_a: assert property (@(posedge ref_clk) disable iff (srst)
        calStart_q |-> $past(wrEn) && $past(regWrData[0]) && !$past(calEnableBit))
        else $error("calibration start without a rising enable write");

    reset_value_a: assert property (@(posedge ref_clk)
        srst |=> sysrefCalConfigReg_q == 8'h05 && sysrefCalEnableReg_q == 8'h00 && tadReg_q == 17'h00000)
        else $error("register reset value wrong");

    code_split_a: assert property (@(posedge ref_clk) disable iff (srst)
        wrCfg ##1 !wrCfg |=> calAveragingCode_q == $past(regWrData[3:2], 2)
            && accumulationDurationCode_q == $past(regWrData[1:0], 2))
        else $error("averaging or duration code taken from wrong bits");

    done_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
        calCompleteFlag_q |-> $past(calEnableBit))
        else $error("complete flag seen while calibration disabled");

    status_read_a: assert property (@(posedge ref_clk) disable iff (srst)
        regRdEn && regAddr == sysref_cal_pkg::ADDR_STAT |=> regRdData_q[16:0] == $past(ctl.result)
            && regRdData_q[sysref_cal_pkg::DONE_BIT] == $past(calEnableBit && ctl.done))
        else $error("status read does not show flag and result");

    supply_bits_a: assert property (@(posedge ref_clk) disable iff (srst)
        wrNoise ##1 !wrNoise |=> digitalSupplyNoiseSuppress_q == $past(regWrData[5], 2)
            && clockSupplyNoiseSuppress_q == $past(regWrData[4], 2))
        else $error("noise suppression pins do not follow bits 5 and 4");

    held_delay_a: assert property (@(posedge ref_clk) disable iff (srst)
        calCompleteFlag_q && calEnableBit && !calStart_q ##1 calEnableBit |-> $stable(sampleDelay_q))
        else $error("calibrated delay moved while held");

    // register stores, start pulse and pin copies, one edge behind their cause
    start_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
        calStart_q |=> !calStart_q)
        else $error("start pulse lasted more than one cycle");

    restart_block_a: assert property (@(posedge ref_clk) disable iff (srst)
        wrEn && calEnableBit |=> !calStart_q)
        else $error("start raised while enable was already set");

    enable_store_a: assert property (@(posedge ref_clk) disable iff (srst)
        wrEn |=> sysrefCalEnableReg_q == $past(regWrData[7:0]))
        else $error("enable register did not store all eight bits");

    cfg_store_a: assert property (@(posedge ref_clk) disable iff (srst)
        wrCfg |=> sysrefCalConfigReg_q == $past(regWrData[7:0]))
        else $error("config register did not store the write");

    tad_store_a: assert property (@(posedge ref_clk) disable iff (srst)
        wrTad |=> tadReg_q == $past(regWrData[sysref_cal_pkg::TAD_W-1:0]))
        else $error("manual delay register did not store the write");

    noise_store_a: assert property (@(posedge ref_clk) disable iff (srst)
        wrNoise |=> noiseSuppressCtrlReg_q == $past(regWrData[7:0]))
        else $error("noise suppression register did not store the write");

    pin_follow_a: assert property (@(posedge ref_clk) disable iff (srst)
        clockSupplyNoiseSuppress_q == $past(noiseSuppressCtrlReg_q[sysref_cal_pkg::CLK_NS_BIT])
            && digitalSupplyNoiseSuppress_q == $past(noiseSuppressCtrlReg_q[sysref_cal_pkg::DIG_NS_BIT]))
        else $error("suppression pins do not follow their register bits");

    flag_drop_a: assert property (@(posedge ref_clk) disable iff (srst)
        !calEnableBit |=> !calCompleteFlag_q)
        else $error("complete flag stayed up after calibration was disabled");

    flag_rise_a: assert property (@(posedge ref_clk) disable iff (srst)
        calEnableBit && ctl.done |=> calCompleteFlag_q)
        else $error("complete flag missing after a finished pass");

    cal_source_a: assert property (@(posedge ref_clk) disable iff (srst)
        calEnableBit |=> sampleDelay_q == $past(ctl.result))
        else $error("delay output not taken from calibration while enabled");

    read_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        !regRdEn |=> $stable(regRdData_q))
        else $error("read data changed without a read");

endmodule : sysref_timing_calibration_ctrl

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the sysref timing calibration control
// Assumes: CalUnit is set to 1, so the pass time bound is 4^(avg+dur+2) cycles
// Notes:   inputs move 1 ns after the rising edge; derived outputs lag registers by one cycle
`timescale 1ns/1ps
module tb;
    // ********************************************************
    // signals, clock and design
    // ********************************************************
    logic                                  ref_clk;
    logic                                  srst;
    logic [sysref_cal_pkg::ADDR_W-1:0]     regAddr;
    logic [sysref_cal_pkg::DATA_W-1:0]     regWrData;
    logic                                  regWrEn;
    logic                                  regRdEn;
    logic [sysref_cal_pkg::DATA_W-1:0]     regRdData_q;
    logic                                  measDone;
    logic [sysref_cal_pkg::TAD_W-1:0]      measDelay;
    logic                                  calStart_q;
    logic [sysref_cal_pkg::CODE_W-1:0]     calAveragingCode_q;
    logic [sysref_cal_pkg::CODE_W-1:0]     accumulationDurationCode_q;
    logic                                  calCompleteFlag_q;
    logic [sysref_cal_pkg::TAD_W-1:0]      sampleDelay_q;
    logic                                  digitalSupplyNoiseSuppress_q;
    logic                                  clockSupplyNoiseSuppress_q;
    logic [sysref_cal_pkg::DATA_W-1:0]     rdVal;
    int                                    errors;
    int                                    totalChecks;
    int                                    cycles;
    int                                    starts;

    // free-running 40 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    sysref_timing_calibration_ctrl #(.CalUnit(1)) i_sysref_timing_calibration_ctrl (
        .ref_clk                      (ref_clk),
        .srst                         (srst),
        .regAddr                      (regAddr),
        .regWrData                    (regWrData),
        .regWrEn                      (regWrEn),
        .regRdEn                      (regRdEn),
        .regRdData_q                  (regRdData_q),
        .measDone                     (measDone),
        .measDelay                    (measDelay),
        .calStart_q                   (calStart_q),
        .calAveragingCode_q           (calAveragingCode_q),
        .accumulationDurationCode_q   (accumulationDurationCode_q),
        .calCompleteFlag_q            (calCompleteFlag_q),
        .sampleDelay_q                (sampleDelay_q),
        .digitalSupplyNoiseSuppress_q (digitalSupplyNoiseSuppress_q),
        .clockSupplyNoiseSuppress_q   (clockSupplyNoiseSuppress_q)
    );

    // ********************************************************
    // watchdog and start-pulse counter
    // ********************************************************
    // starts counted at the edge, so a one-cycle pulse is never missed between tasks
    always @(posedge ref_clk)
    begin
        cycles++;
        if (calStart_q === 1'b1)
            starts++;
        if (cycles == 5000)
        begin
            errors++;
            testDone();
        end
    end

    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic testDone;
        $display("checks %0d errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : testDone

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    // write strobe held through exactly one taking edge
    task automatic wr(input logic [11:0] a, input logic [23:0] d);
        step(1);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        step(1);
        regWrEn = 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [23:0] d);
        step(1);
        regAddr = a;
        regRdEn = 1'b1;
        step(1);
        regRdEn = 1'b0;
        d = regRdData_q;
    endtask : rd

    // measurement result presented with a one-cycle measDone pulse
    task automatic pulseMeas(input logic [16:0] v);
        measDelay = v;
        measDone = 1'b1;
        step(1);
        measDone = 1'b0;
    endtask : pulseMeas

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic resetValues;
        rd(12'h2a2, rdVal);
        check(rdVal, 24'h000000);
        rd(12'h2b0, rdVal);
        check(rdVal, 24'h000000);
        rd(12'h2b1, rdVal);
        check(rdVal, 24'h000005);
        rd(12'h123, rdVal);
        check(rdVal, 24'h000000);
        check(24'(calAveragingCode_q), 24'h000001);
        check(24'(accumulationDurationCode_q), 24'h000001);
        check(24'(calCompleteFlag_q), 24'h000000);
    endtask : resetValues

    task automatic noiseBits;
        wr(12'h2a2, 24'h000020);
        step(1);
        check(24'({digitalSupplyNoiseSuppress_q, clockSupplyNoiseSuppress_q}), 24'h000002);
        wr(12'h2a2, 24'h0000cf);
        step(1);
        check(24'({digitalSupplyNoiseSuppress_q, clockSupplyNoiseSuppress_q}), 24'h000000);
        wr(12'h2a2, 24'h000010);
        step(1);
        check(24'({digitalSupplyNoiseSuppress_q, clockSupplyNoiseSuppress_q}), 24'h000001);
    endtask : noiseBits

    // every code pair, with the reserved nibble echoing the code
    task automatic configCodes;
        for (int c = 0; c < 16; c++)
        begin
            wr(12'h2b1, 24'(c * 17));
            step(1);
            check(24'(calAveragingCode_q), 24'(c / 4));
            check(24'(accumulationDurationCode_q), 24'(c % 4));
            rd(12'h2b1, rdVal);
            check(rdVal, 24'(c * 17));
        end
    endtask : configCodes

    task automatic manualDelay;
        int n0;
        wr(12'h2b5, 24'h01abcd);
        step(1);
        check(24'(sampleDelay_q), 24'h01abcd);
        n0 = starts;
        wr(12'h2b0, 24'h0000fe);
        step(3);
        check(24'(starts - n0), 24'h000000);
        rd(12'h2b0, rdVal);
        check(rdVal, 24'h0000fe);
        check(24'(sampleDelay_q), 24'h01abcd);
        wr(12'h2b0, 24'h000000);
    endtask : manualDelay

    task automatic measuredPass;
        int n0;
        wr(12'h2b1, 24'h00000f);
        n0 = starts;
        wr(12'h2b0, 24'h000001); // no converter calibration runs in this bench
        step(3);
        check(24'(starts - n0), 24'h000001);
        check(24'(calCompleteFlag_q), 24'h000000);
        pulseMeas(17'h15a3c);
        step(3);
        check(24'(calCompleteFlag_q), 24'h000001);
        check(24'(sampleDelay_q), 24'h015a3c);
        rd(12'h2b2, rdVal);
        check(rdVal, 24'h035a3c);
        wr(12'h2b5, 24'h000001);
        wr(12'h2b0, 24'h000001);
        pulseMeas(17'h00777);
        step(2);
        check(24'(sampleDelay_q), 24'h015a3c);
        check(24'(starts - n0), 24'h000001);
        wr(12'h2b0, 24'h000000);
        rd(12'h2b2, rdVal);
        check(rdVal, 24'h015a3c);
        step(2);
        check(24'(calCompleteFlag_q), 24'h000000);
        check(24'(sampleDelay_q), 24'h000001);
    endtask : measuredPass

    // no measurement arrives: the pass must end at 4^2 = 16 cycles
    task automatic boundedPass;
        int n;
        wr(12'h2b1, 24'h000000);
        wr(12'h2b0, 24'h000001);
        n = 0;
        while (calCompleteFlag_q !== 1'b1 && n < 40)
        begin
            step(1);
            n++;
        end
        check(24'(n >= 16 && n <= 20), 24'h000001);
        check(24'(sampleDelay_q), 24'h015a3c);
        wr(12'h2b0, 24'h000000);
    endtask : boundedPass

    // ********************************************************
    // main sequence
    // ********************************************************
    initial
    begin
        errors = 0;
        totalChecks = 0;
        cycles = 0;
        starts = 0;
        srst = 1'b1;
        regAddr = 12'h000;
        regWrData = 24'h000000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        measDone = 1'b0;
        measDelay = 17'h00000;
        step(2);
        srst = 1'b0;
        resetValues();
        noiseBits();
        configCodes();
        manualDelay();
        measuredPass();
        boundedPass();
        testDone();
    end
endmodule : tb
